// File: design/gpio_ports_map.vh
// Register offsets, field positions and reset values of the parallel ports.
`ifndef GPIO_PORTS_MAP_VH
`define GPIO_PORTS_MAP_VH

`define ADDR_W            4
`define DATA_W            8

`define OFS_PORT_A_DATA   4'h0
`define OFS_PORT_B_DATA   4'h1
`define OFS_PORT_C_DATA   4'h2
`define OFS_PORT_D_DATA   4'h3
`define OFS_PORT_A_DIR    4'h4
`define OFS_PORT_B_DIR    4'h5
`define OFS_PORT_C_DIR    4'h6
`define OFS_PORT_D_DIR    4'h7

`define PORT_A_WIDTH      7
`define PORT_B_WIDTH      8
`define PORT_C_WIDTH      5
`define PORT_D_WIDTH      2

`define DIR_RESET         8'h00
`define CLKOUT_EN_BIT     7
`define CLKOUT_PIN        2
`define CLKOUT_EN_RESET   1'b0
`define TMR_PIN_LO        6
`define READ_IDLE         8'h00

`endif

// File: design/io_port_bank.v
// One parallel port: data latches, direction bits, pin drivers and read mux.
`timescale 1ns/1ps
module io_port_bank
#(
  parameter WIDTH = 8
)
(
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // Software access
  input  wire [WIDTH-1:0] lat_we,
  input  wire             dir_we,
  input  wire [WIDTH-1:0] wdata,
  output wire [WIDTH-1:0] read_value,
  output wire [WIDTH-1:0] dir,
  // Alternate function override per pin
  input  wire [WIDTH-1:0] alt_sel,
  input  wire [WIDTH-1:0] alt_oe,
  input  wire [WIDTH-1:0] alt_val,
  // Pin
  input  wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_out,
  output wire [WIDTH-1:0] pin_oe_n
);

  reg [WIDTH-1:0] latch_q;
  reg [WIDTH-1:0] dir_q;
  reg [WIDTH-1:0] out_q;
  reg [WIDTH-1:0] oe_n_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      // The latch has no reset so its contents survive a system reset.
      always @(posedge clk)
      begin
        if (lat_we[i])
          latch_q[i] <= wdata[i];
      end

      always @(posedge clk)
      begin
        if (!rst_n)
          dir_q[i] <= 1'b0;
        else if (dir_we)
          dir_q[i] <= wdata[i];
      end

      always @(posedge clk)
      begin
        if (!rst_n)
        begin
          out_q[i]  <= 1'b0;
          oe_n_q[i] <= 1'b1;
        end
        else if (alt_sel[i])
        begin
          out_q[i]  <= alt_val[i];
          oe_n_q[i] <= ~alt_oe[i];
        end
        else
        begin
          out_q[i]  <= latch_q[i];
          oe_n_q[i] <= ~dir_q[i];
        end
      end

      // Output mode reads the latch, input mode reads the pin.
      assign read_value[i] = dir_q[i] ? latch_q[i] : pin_in[i];
    end
  endgenerate

  assign dir      = dir_q;
  assign pin_out  = out_q;
  assign pin_oe_n = oe_n_q;

endmodule

// File: design/parallel_io_ports.v
// Four memory-mapped parallel I/O ports with pin sharing and clock output.
//
// Behaviour
// - Reset clears every direction bit; all pins start as high-impedance inputs.
// - Direction 1 enables the pin's output buffer; 0 makes it an input.
// - Output-mode bits read back the stored latch value, except port C pin two, which reads zero while the clock output owns it.
// - Input-mode bits read back the sampled pin level, except port C pin two, which reads zero while the clock output owns it.
// - Data writes update the latch regardless of direction, except port C pin two while the clock output owns it.
// - Reset leaves data latches unchanged; only direction and clock enable reset.
// - Port A has seven pins with direction bits six to zero.
// - Port B has eight pins, all shared with converter, some with timer.
// - On port B pins six and seven the converter beats the timer.
// - A converter-selected pin is joined to the converter, cut from timer.
// - Port C has five bidirectional pins; pin two is shared with the clock output.
// - With clock output enabled, port C pin two outputs the bus clock.
// - Reset clears the clock output enable, so pin two starts as input.
// - Port D has two pins shared with the first timer.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "gpio_ports_map.vh"
module parallel_io_ports
#(
  parameter PA_W = `PORT_A_WIDTH,
  parameter PB_W = `PORT_B_WIDTH,
  parameter PC_W = `PORT_C_WIDTH,
  parameter PD_W = `PORT_D_WIDTH
)
(
  // Clock and reset
  input  wire                 CLK_SYS,
  input  wire                 RST_N,
  // Register port
  input  wire [`ADDR_W-1:0]   ADDR,
  input  wire [`DATA_W-1:0]   WDATA,
  input  wire                 WR,
  input  wire                 RD,
  output wire [`DATA_W-1:0]   RDATA,
  // Port A pins
  input  wire [PA_W-1:0]      PA_IN,
  output wire [PA_W-1:0]      PA_OUT,
  output wire [PA_W-1:0]      PA_OE_N,
  // Port B pins
  input  wire [PB_W-1:0]      PB_IN,
  output wire [PB_W-1:0]      PB_OUT,
  output wire [PB_W-1:0]      PB_OE_N,
  // Port C pins
  input  wire [PC_W-1:0]      PC_IN,
  output wire [PC_W-1:0]      PC_OUT,
  output wire [PC_W-1:0]      PC_OE_N,
  // Port D pins
  input  wire [PD_W-1:0]      PD_IN,
  output wire [PD_W-1:0]      PD_OUT,
  output wire [PD_W-1:0]      PD_OE_N,
  // Analog converter channel selection
  input  wire [PB_W-1:0]      ADC_SEL,
  output wire [PB_W-1:0]      ADC_CONN,
  // Second timer channels on port B pins six and seven
  input  wire [1:0]           TMR2_EN,
  input  wire [1:0]           TMR2_OE,
  input  wire [1:0]           TMR2_OUT,
  output wire [1:0]           TMR2_IN,
  // First timer channels on port D
  input  wire [PD_W-1:0]      TMR1_EN,
  input  wire [PD_W-1:0]      TMR1_OE,
  input  wire [PD_W-1:0]      TMR1_OUT,
  output wire [PD_W-1:0]      TMR1_IN
);

  // Address decode.
  wire                sel_a_data;
  wire                sel_b_data;
  wire                sel_c_data;
  wire                sel_d_data;
  wire                sel_a_dir;
  wire                sel_b_dir;
  wire                sel_c_dir;
  wire                sel_d_dir;

  // Addresses 0x8 to 0xf select nothing, so they read zero and ignore writes.
  assign sel_a_data = (ADDR == `OFS_PORT_A_DATA);
  assign sel_b_data = (ADDR == `OFS_PORT_B_DATA);
  assign sel_c_data = (ADDR == `OFS_PORT_C_DATA);
  assign sel_d_data = (ADDR == `OFS_PORT_D_DATA);
  assign sel_a_dir  = (ADDR == `OFS_PORT_A_DIR);
  assign sel_b_dir  = (ADDR == `OFS_PORT_B_DIR);
  assign sel_c_dir  = (ADDR == `OFS_PORT_C_DIR);
  assign sel_d_dir  = (ADDR == `OFS_PORT_D_DIR);

  // Clock output enable. It sits beside the port C direction bits, so one
  // write can hand pin two to the clock and set the other pins at once.
  reg                 clkout_en_d;
  reg                 clkout_en_q;

  always @*
  begin
    if (WR && sel_c_dir)
      clkout_en_d = WDATA[`CLKOUT_EN_BIT];
    else
      clkout_en_d = clkout_en_q;
  end

  always @(posedge CLK_SYS)
  begin
    if (!RST_N)
      clkout_en_q <= `CLKOUT_EN_RESET;
    else
      clkout_en_q <= clkout_en_d;
  end

  // Port A.
  wire [PA_W-1:0]     a_read;
  wire [PA_W-1:0]     a_dir;

  io_port_bank
  #(
    .WIDTH (PA_W)
  )
  u_port_a
  (
    .clk        (CLK_SYS),
    .rst_n      (RST_N),
    .lat_we     ({PA_W{WR & sel_a_data}}),
    .dir_we     (WR & sel_a_dir),
    .wdata      (WDATA[PA_W-1:0]),
    .read_value (a_read),
    .dir        (a_dir),
    .alt_sel    ({PA_W{1'b0}}),
    .alt_oe     ({PA_W{1'b0}}),
    .alt_val    ({PA_W{1'b0}}),
    .pin_in     (PA_IN),
    .pin_out    (PA_OUT),
    .pin_oe_n   (PA_OE_N)
  );

  // Port B sharing. Every pin can be a converter input; pins six and
  // seven also carry the second timer, and the converter takes priority.
  wire [PB_W-1:0]     b_read;
  wire [PB_W-1:0]     b_dir;
  wire [1:0]          tmr2_owns;
  wire [PB_W-1:0]     b_alt_sel;
  wire [PB_W-1:0]     b_alt_oe;
  wire [PB_W-1:0]     b_alt_val;

  assign tmr2_owns = TMR2_EN & ~ADC_SEL[`TMR_PIN_LO+1:`TMR_PIN_LO];

  // A converter pin is forced to input so no buffer fights the analog level.
  assign b_alt_sel = ADC_SEL | {tmr2_owns, {`TMR_PIN_LO{1'b0}}};
  assign b_alt_oe  = {tmr2_owns & TMR2_OE, {`TMR_PIN_LO{1'b0}}};
  // Pins zero to five have no timer, so their alternate drive value is tied low.
  assign b_alt_val = {TMR2_OUT, {`TMR_PIN_LO{1'b0}}};

  io_port_bank
  #(
    .WIDTH (PB_W)
  )
  u_port_b
  (
    .clk        (CLK_SYS),
    .rst_n      (RST_N),
    .lat_we     ({PB_W{WR & sel_b_data}}),
    .dir_we     (WR & sel_b_dir),
    .wdata      (WDATA[PB_W-1:0]),
    .read_value (b_read),
    .dir        (b_dir),
    .alt_sel    (b_alt_sel),
    .alt_oe     (b_alt_oe),
    .alt_val    (b_alt_val),
    .pin_in     (PB_IN),
    .pin_out    (PB_OUT),
    .pin_oe_n   (PB_OE_N)
  );

  // Converter connection and timer capture inputs.
  reg  [PB_W-1:0]     adc_conn_q;
  reg  [1:0]          tmr2_in_q;

  always @(posedge CLK_SYS)
  begin
    if (!RST_N)
      adc_conn_q <= {PB_W{1'b0}};
    else
      adc_conn_q <= ADC_SEL;
  end

  // The timer sees the pin only while it owns it, so a converter pin never
  // feeds a capture edge into the timer.
  always @(posedge CLK_SYS)
  begin
    if (!RST_N)
      tmr2_in_q <= 2'b00;
    else
      tmr2_in_q <= PB_IN[`TMR_PIN_LO+1:`TMR_PIN_LO] & tmr2_owns;
  end

  assign ADC_CONN = adc_conn_q;
  assign TMR2_IN  = tmr2_in_q;

  // Port C. Pin two is handed to the clock output while it is enabled.
  wire [PC_W-1:0]     c_read;
  wire [PC_W-1:0]     c_dir;
  wire [PC_W-1:0]     c_pin_out;
  wire [PC_W-1:0]     c_clk_mask;
  wire [PC_W-1:0]     c_lat_we;
  wire [PC_W-1:0]     c_clk_owned;

  assign c_clk_mask  = {{(PC_W-1){1'b0}}, 1'b1} << `CLKOUT_PIN;
  assign c_clk_owned = c_clk_mask & {PC_W{clkout_en_q}};
  // The latch bit under the clock is frozen, so its old value returns on disable.
  assign c_lat_we    = {PC_W{WR & sel_c_data}} & ~c_clk_owned;

  io_port_bank
  #(
    .WIDTH (PC_W)
  )
  u_port_c
  (
    .clk        (CLK_SYS),
    .rst_n      (RST_N),
    .lat_we     (c_lat_we),
    .dir_we     (WR & sel_c_dir),
    .wdata      (WDATA[PC_W-1:0]),
    .read_value (c_read),
    .dir        (c_dir),
    .alt_sel    (c_clk_owned),
    .alt_oe     (c_clk_mask),
    .alt_val    ({PC_W{1'b0}}),
    .pin_in     (PC_IN),
    .pin_out    (c_pin_out),
    .pin_oe_n   (PC_OE_N)
  );

  // The clock output cannot come from a flop at full bus rate, so the
  // registered select gates the bus clock itself onto the pin.
  // Limitation: the pin's duty cycle and skew follow the bus clock tree.
  reg                 clk_to_pin_q;

  always @(posedge CLK_SYS)
  begin
    if (!RST_N)
      clk_to_pin_q <= 1'b0;
    else
      clk_to_pin_q <= clkout_en_q;
  end

  genvar k;
  generate
    for (k = 0; k < PC_W; k = k + 1)
    begin : g_pc_out
      if (k == `CLKOUT_PIN)
      begin : g_clk
        assign PC_OUT[k] = clk_to_pin_q ? CLK_SYS : c_pin_out[k];
      end
      else
      begin : g_pass
        assign PC_OUT[k] = c_pin_out[k];
      end
    end
  endgenerate

  // Port D. A timer channel that is enabled owns its pin.
  wire [PD_W-1:0]     d_read;
  wire [PD_W-1:0]     d_dir;
  reg  [PD_W-1:0]     tmr1_in_q;

  io_port_bank
  #(
    .WIDTH (PD_W)
  )
  u_port_d
  (
    .clk        (CLK_SYS),
    .rst_n      (RST_N),
    .lat_we     ({PD_W{WR & sel_d_data}}),
    .dir_we     (WR & sel_d_dir),
    .wdata      (WDATA[PD_W-1:0]),
    .read_value (d_read),
    .dir        (d_dir),
    .alt_sel    (TMR1_EN),
    .alt_oe     (TMR1_OE),
    .alt_val    (TMR1_OUT),
    .pin_in     (PD_IN),
    .pin_out    (PD_OUT),
    .pin_oe_n   (PD_OE_N)
  );

  // A disabled channel sees a steady zero rather than the pin.
  always @(posedge CLK_SYS)
  begin
    if (!RST_N)
      tmr1_in_q <= {PD_W{1'b0}};
    else
      tmr1_in_q <= PD_IN & TMR1_EN;
  end

  assign TMR1_IN = tmr1_in_q;

  // Read mux. Data appears in the cycle after the strobe and only there.
  reg  [`DATA_W-1:0]  rd_mux;
  reg  [`DATA_W-1:0]  rdata_d;
  reg  [`DATA_W-1:0]  rdata_q;
  reg  [PC_W-1:0]     c_read_masked;

  always @*
  begin
    c_read_masked = c_read & ~c_clk_owned;
    rd_mux        = `READ_IDLE;
    case (1'b1)
      sel_a_data: rd_mux[PA_W-1:0] = a_read;
      sel_b_data: rd_mux[PB_W-1:0] = b_read;
      sel_c_data: rd_mux[PC_W-1:0] = c_read_masked;
      sel_d_data: rd_mux[PD_W-1:0] = d_read;
      sel_a_dir:  rd_mux[PA_W-1:0] = a_dir;
      sel_b_dir:  rd_mux[PB_W-1:0] = b_dir;
      sel_c_dir:
      begin
        rd_mux[PC_W-1:0]           = c_dir;
        rd_mux[`CLKOUT_EN_BIT]     = clkout_en_q;
      end
      sel_d_dir:  rd_mux[PD_W-1:0] = d_dir;
      default:    rd_mux           = `READ_IDLE;
    endcase
  end

  // Idle cycles return zero, so a stale byte is never taken for a fresh read.
  always @*
  begin
    if (RD)
      rdata_d = rd_mux;
    else
      rdata_d = `READ_IDLE;
  end

  always @(posedge CLK_SYS)
  begin
    if (!RST_N)
      rdata_q <= `READ_IDLE;
    else
      rdata_q <= rdata_d;
  end

  assign RDATA = rdata_q;

endmodule

// File: bench/parallel_io_ports_properties.sv
// Port-level checker of the parallel ports.
`timescale 1ns/1ps
module parallel_io_ports_checker
#(
  parameter PA_W = 7
)
(
  // Clock and reset
  input wire            CLK_SYS,
  input wire            RST_N,
  // Register port
  input wire [3:0]      ADDR,
  input wire [7:0]      WDATA,
  input wire            WR,
  input wire            RD,
  input wire [7:0]      RDATA,
  // Pins and alternate functions
  input wire [PA_W-1:0] PA_IN,
  input wire [PA_W-1:0] PA_OE_N,
  input wire [7:0]      PB_OE_N,
  input wire [4:0]      PC_OE_N,
  input wire [1:0]      PD_IN,
  input wire [7:0]      ADC_SEL,
  input wire [7:0]      ADC_CONN,
  input wire [1:0]      TMR2_EN,
  input wire [1:0]      TMR2_IN,
  input wire [1:0]      TMR1_EN,
  input wire [1:0]      TMR1_IN
);
  wire [PA_W-1:0] wd_a = WDATA[PA_W-1:0];
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // Reset itself is the cause here, so this one is never disabled.
  property p_rst_dir;
    disable iff (1'b0) !RST_N |=> (&PA_OE_N && &PB_OE_N && &PC_OE_N);
  endproperty
  a_rst_dir: assert property (p_rst_dir) else $error("pins driven after reset");
  property p_unmapped;
    RD && ADDR[3] |=> RDATA == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_a_top;
    RD && ADDR == 4'h0 |=> !RDATA[7];
  endproperty
  a_a_top: assert property (p_a_top) else $error("port A bit seven set");
  property p_dir_a;
    WR && ADDR == 4'h4 ##1 !WR |=> PA_OE_N == ~$past(wd_a, 2);
  endproperty
  a_dir_a: assert property (p_dir_a) else $error("port A enables wrong");
  property p_in_read;
    RD && ADDR == 4'h0 && &PA_OE_N && !$past(WR) |=> RDATA[PA_W-1:0] == $past(PA_IN);
  endproperty
  a_in_read: assert property (p_in_read) else $error("input read not pin");
  property p_clk_en;
    WR && ADDR == 4'h6 && WDATA[7] ##1 !WR |=> !PC_OE_N[2];
  endproperty
  a_clk_en: assert property (p_clk_en) else $error("clock pin not driven");
  property p_adc_prio;
    ADC_SEL[6] && TMR2_EN[0] |=> PB_OE_N[6] && !TMR2_IN[0];
  endproperty
  a_adc_prio: assert property (p_adc_prio) else $error("timer kept pin six");
  property p_adc_conn;
    $past(RST_N) |-> ADC_CONN == $past(ADC_SEL);
  endproperty
  a_adc_conn: assert property (p_adc_conn) else $error("converter link wrong");
  property p_tmr1_in;
    $past(RST_N) |-> TMR1_IN == ($past(PD_IN) & $past(TMR1_EN));
  endproperty
  a_tmr1_in: assert property (p_tmr1_in) else $error("first timer input wrong");
  c_dir_a: cover property (WR && ADDR == 4'h4);
  c_clk_en: cover property (WR && ADDR == 4'h6 && WDATA[7]);
  c_prio: cover property (ADC_SEL[6] && TMR2_EN[0]);
endmodule

bind parallel_io_ports parallel_io_ports_checker #(.PA_W(PA_W)) i_chk (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .PA_IN(PA_IN), .PA_OE_N(PA_OE_N), .PB_OE_N(PB_OE_N), .PC_OE_N(PC_OE_N),
  .PD_IN(PD_IN), .ADC_SEL(ADC_SEL), .ADC_CONN(ADC_CONN), .TMR2_EN(TMR2_EN),
  .TMR2_IN(TMR2_IN), .TMR1_EN(TMR1_EN), .TMR1_IN(TMR1_IN));

// File: bench/pin_board_model.sv
// Board-side model that resolves each port pin.
`timescale 1ns/1ps
module pin_board_model
#(
  parameter W = 8
)
(
  // Port side
  input  wire [W-1:0] pin_out,
  input  wire [W-1:0] pin_oe_n,
  // Board side
  input  wire [W-1:0] board_val,
  output wire [W-1:0] pin_lvl
);
  // A driven pin follows the port; a released one shows the board's level.
  assign pin_lvl = (pin_out & ~pin_oe_n) | (board_val & pin_oe_n);
endmodule

// File: bench/tb_parallel_io_ports.sv
// Self-checking testbench of the parallel ports.
`timescale 1ns/1ps
module tb_parallel_io_ports;
  localparam logic [7:0] BOARD = 8'ha5;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] adc_sel = 8'h00;
  logic [1:0] t2_en = 2'h0, t2_oe = 2'h0, t2_out = 2'h0;
  logic [1:0] t1_en = 2'h0, t1_oe = 2'h0, t1_out = 2'h0;
  wire  [7:0] rdata, adc_conn, pb_in, pb_out, pb_oe_n;
  wire  [6:0] pa_in, pa_out, pa_oe_n;
  wire  [4:0] pc_in, pc_out, pc_oe_n;
  wire  [1:0] pd_in, pd_out, pd_oe_n, t2_in, t1_in;
  logic [7:0] mask [4] = '{8'h7f, 8'hff, 8'h1f, 8'h03};
  int         num_errors = 0;
  int         checks_done = 0;

  pin_board_model #(.W(7)) i_brd_a (.pin_out(pa_out), .pin_oe_n(pa_oe_n),
    .board_val(BOARD[6:0]), .pin_lvl(pa_in));
  pin_board_model #(.W(8)) i_brd_b (.pin_out(pb_out), .pin_oe_n(pb_oe_n),
    .board_val(BOARD), .pin_lvl(pb_in));
  pin_board_model #(.W(5)) i_brd_c (.pin_out(pc_out), .pin_oe_n(pc_oe_n),
    .board_val(BOARD[4:0]), .pin_lvl(pc_in));
  pin_board_model #(.W(2)) i_brd_d (.pin_out(pd_out), .pin_oe_n(pd_oe_n),
    .board_val(BOARD[1:0]), .pin_lvl(pd_in));
  parallel_io_ports i_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .PA_IN(pa_in), .PA_OUT(pa_out), .PA_OE_N(pa_oe_n),
    .PB_IN(pb_in), .PB_OUT(pb_out), .PB_OE_N(pb_oe_n), .PC_IN(pc_in), .PC_OUT(pc_out),
    .PC_OE_N(pc_oe_n), .PD_IN(pd_in), .PD_OUT(pd_out), .PD_OE_N(pd_oe_n),
    .ADC_SEL(adc_sel), .ADC_CONN(adc_conn), .TMR2_EN(t2_en), .TMR2_OE(t2_oe),
    .TMR2_OUT(t2_out), .TMR2_IN(t2_in), .TMR1_EN(t1_en), .TMR1_OE(t1_oe),
    .TMR1_OUT(t1_out), .TMR1_IN(t1_in));

  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 chk("read data", exp, rdata);
  endtask

  function automatic logic [7:0] oe_of(input int p);
    case (p)
      0: return {1'b0, pa_oe_n};
      1: return pb_oe_n;
      2: return {3'h0, pc_oe_n};
      default: return {6'h0, pd_oe_n};
    endcase
  endfunction

  // Timeout well beyond the roughly 120 cycles that the tests take.
  initial
  begin
    #100000;
    num_errors++;
    results();
  end

  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int p = 0; p < 4; p++)
    begin
      rd_reg(4'h4 + p[3:0], 8'h00);
      chk("enables", mask[p], oe_of(p));
      wr_reg(p[3:0], 8'hff);
      rd_reg(p[3:0], BOARD & mask[p]);
      wr_reg(4'h4 + p[3:0], 8'h7f);
      rd_reg(4'h4 + p[3:0], 8'h7f & mask[p]);
      rd_reg(p[3:0], mask[p]);
      chk("enables", mask[p] & 8'h80, oe_of(p));
    end
    chk("port A drive", 8'h7f, {1'b0, pa_out});
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int p = 0; p < 4; p++)
    begin
      rd_reg(4'h4 + p[3:0], 8'h00);
      wr_reg(4'h4 + p[3:0], 8'h7f);
      rd_reg(p[3:0], mask[p]);
    end
    wr_reg(4'h6, 8'h80);
    rd_reg(4'h6, 8'h80);
    wr_reg(4'h2, 8'h00);
    rd_reg(4'h2, 8'h01);
    @(posedge clk_sys);
    #1 chk("clock pin high", 8'h01, {7'h0, pc_out[2]});
    chk("clock pin enable", 8'h00, {7'h0, pc_oe_n[2]});
    @(negedge clk_sys);
    #1 chk("clock pin low", 8'h00, {7'h0, pc_out[2]});
    wr_reg(4'h6, 8'h04);
    rd_reg(4'h2, 8'h05);
    wr_reg(4'h9, 8'hff);
    rd_reg(4'h9, 8'h00);
    wr_reg(4'h5, 8'h00);
    @(posedge clk_sys);
    t2_en <= 2'b11;
    t2_oe <= 2'b01;
    t2_out <= 2'b01;
    t1_en <= 2'b11;
    t1_oe <= 2'b11;
    t1_out <= 2'b10;
    repeat (3) @(posedge clk_sys);
    #1 chk("timer drive", 8'h00, {7'h0, pb_oe_n[6]});
    chk("timer drive value", 8'h01, {7'h0, pb_out[6]});
    chk("timer input", 8'h03, {6'h0, t2_in});
    chk("first timer drive", 8'h02, {6'h0, pd_out});
    chk("first timer input", 8'h02, {6'h0, t1_in});
    @(posedge clk_sys);
    adc_sel <= 8'h40;
    repeat (3) @(posedge clk_sys);
    #1 chk("converter owns pin", 8'h01, {7'h0, pb_oe_n[6]});
    chk("converter link", 8'h40, adc_conn);
    chk("timer cut off", 8'h00, {7'h0, t2_in[0]});
    @(posedge clk_sys);
    t2_en <= 2'b00;
    wr_reg(4'h5, 8'hff);
    @(posedge clk_sys);
    adc_sel <= 8'hc0;
    repeat (3) @(posedge clk_sys);
    #1 chk("converter forces input", 8'hc0, pb_oe_n);
    chk("converter pins", 8'hc0, adc_conn);
    chk("timer inputs off", 8'h00, {6'h0, t2_in});
    results();
  end
endmodule
